// ==== inc/tcu_defs.vh ====
// Register offsets, field positions, mode codes and reset values of the timer capture unit.
`ifndef TCU_DEFS_VH
`define TCU_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TCU_OFS_STD_CTRL 8'h00
`define TCU_OFS_ENH_CTRL 8'h04
`define TCU_OFS_STD_VAL 8'h08
`define TCU_OFS_ENH_VAL 8'h0c
`define TCU_OFS_T3_CTRL 8'h10
`define TCU_OFS_BUS_IO 8'h14
`define TCU_OFS_FLAGS 8'h18
`define TCU_OFS_IRQ_EN 8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TCU_MODE_MSB 3
`define TCU_BIT_STD 0
`define TCU_BIT_ENH 1
`define TCU_BIT_MSG_SEL 0
`define TCU_VAL_MSB 15

// ----------------------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------------------
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_CMP_TGL 4'h2
`define TCU_MODE_CAP_FALL 4'h4
`define TCU_MODE_CAP_RISE 4'h5
`define TCU_MODE_CAP_DIV4 4'h6
`define TCU_MODE_CAP_DIV16 4'h7
`define TCU_MODE_CMP_SEV 4'hb
`define TCU_GRP_CAP 2'h1
`define TCU_GRP_CMP 2'h2
`define TCU_GRP_PWM 2'h3

// ----------------------------------------------------------------------------
// Prescaler terminal counts and time base codes
// ----------------------------------------------------------------------------
`define TCU_LAST_DIV4 4'h3
`define TCU_LAST_DIV16 4'hf
`define TCU_TB_FIRST 2'h0
`define TCU_TB_SECOND 2'h1
`define TCU_TB_THIRD 2'h2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TCU_RST_MODE 4'h0
`define TCU_RST_VAL 16'h0000
`define TCU_RST_BITS 2'h0

`endif

// ==== testbench/tcu_checker.sv ====
// Port-level checks on the timer capture unit.
`include "tcu_defs.vh"
module tcu_checker #(
	parameter ADDR_W = 8
) (
	input wire CLK_I,
	input wire RST_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire PREADY_O,
	input wire PSLVERR_O,
	input wire [1:0] STD_TIMEBASE_O,
	input wire [1:0] ENH_TIMEBASE_O,
	input wire FIRST_TIMER_CLR_O,
	input wire THIRD_TIMER_CLR_O,
	input wire ADC_START_O,
	input wire STD_FLAG_O,
	input wire ENH_FLAG_O,
	input wire STD_IRQ_O,
	input wire ENH_IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	// A flag may only drop on a write-one-clear access to the flag word.
	wire clr_w = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == `TCU_OFS_FLAGS);
	sequence s_clr_drop;
		##1 !FIRST_TIMER_CLR_O;
	endsequence
	sequence s_adc_drop;
		##1 !ADC_START_O;
	endsequence
	sequence s_clr3_drop;
		##1 !THIRD_TIMER_CLR_O;
	endsequence
	a_ready_always: assert property (PREADY_O) else $error("pready low");
	a_err_access: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("pslverr outside access");
	a_std_flag_hold: assert property (STD_FLAG_O && !(clr_w && PWDATA_I[0]) |=> STD_FLAG_O)
		else $error("std flag dropped");
	a_enh_flag_hold: assert property (ENH_FLAG_O && !(clr_w && PWDATA_I[1]) |=> ENH_FLAG_O)
		else $error("enh flag dropped");
	a_irq_gated: assert property (STD_IRQ_O |-> STD_FLAG_O) else $error("irq without flag");
	a_enh_irq_gated: assert property (ENH_IRQ_O |-> ENH_FLAG_O) else $error("enh irq without flag");
	a_base_legal: assert property (STD_TIMEBASE_O != 2'h3 && ENH_TIMEBASE_O != 2'h3)
		else $error("illegal time base");
	// The conversion start rides with the clear of whichever timer the enhanced channel uses.
	a_adc_with_clr: assert property ($rose(ADC_START_O) |-> FIRST_TIMER_CLR_O || THIRD_TIMER_CLR_O)
		else $error("conversion start without clear");
	a_clr_single: assert property (FIRST_TIMER_CLR_O |-> s_clr_drop) else $error("clear pulse too long");
	a_adc_single: assert property (ADC_START_O |-> s_adc_drop) else $error("start pulse too long");
	a_clr3_single: assert property (THIRD_TIMER_CLR_O |-> s_clr3_drop) else $error("third clear too long");
endmodule

// ==== testbench/tcu_evt_src.sv ====
// Event source model: capture pad and message-received strobes.
module tcu_evt_src (
	input wire clk_i,
	input wire rst_n_i,
	input wire tgl_i,
	input wire msg_i,
	input wire [1:0] sel_i,
	output wire pad_o,
	output wire [2:0] msg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pad_r;
	logic [2:0] msg_r;
	assign pad_o = pad_r;
	assign msg_o = msg_r;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_r <= 1'b0;
			msg_r <= 3'h0;
		end else begin
			pad_r <= pad_r ^ tgl_i;
			// One buffer per strobe so each pulse stands for one received message.
			msg_r <= msg_i ? (3'h1 << sel_i) : 3'h0;
		end
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the timer capture unit.
`include "tcu_defs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, pen, pwr, tgl, mreq, lat, oe, serr;
	logic [7:0] paddr;
	logic [31:0] pwdata, rdata;
	logic [1:0] sel;
	logic [15:0] t1, t3;
	wire [31:0] prdata;
	wire pready, pslverr, pad, adc, clr1, sflag, sirq;
	wire [2:0] msg;
	wire [1:0] stb, etb;
	int err_total, checks_done, n_adc, n_clr;
	tcu_top i_tcu_top (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata),
		.STD_PAD_I(pad), .STD_PORT_LAT_I(lat), .STD_PORT_OE_I(oe), .ENH_PAD_I(1'b0), .ENH_PORT_LAT_I(1'b0),
		.ENH_PORT_OE_I(1'b0), .MSG_RX_I(msg), .FIRST_TIMER_I(t1), .THIRD_TIMER_I(t3), .STD_TIMEBASE_O(stb),
		.ENH_TIMEBASE_O(etb), .FIRST_TIMER_CLR_O(clr1), .THIRD_TIMER_CLR_O(), .ADC_START_O(adc),
		.STD_FLAG_O(sflag), .ENH_FLAG_O(), .STD_IRQ_O(sirq), .ENH_IRQ_O());
	tcu_evt_src i_tcu_evt_src (.clk_i(clk), .rst_n_i(rst_n), .tgl_i(tgl), .msg_i(mreq), .sel_i(sel),
		.pad_o(pad), .msg_o(msg));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (adc === 1'b1) n_adc++;
		if (clr1 === 1'b1) n_clr++;
	end
	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	task rv(input logic [15:0] e);
		rc(`TCU_OFS_STD_VAL, {16'h0, e});
	endtask
	task md(input logic [3:0] m);
		wr(`TCU_OFS_STD_CTRL, {28'h0, m});
	endtask
	// Each step is one pad toggle, one port-latch toggle or one message strobe.
	task evt(input int src, input int k);
		repeat (k) begin
			@(posedge clk);
			if (src == 0) tgl <= 1'b1;
			else if (src == 1) lat <= ~lat;
			else mreq <= 1'b1;
			@(posedge clk);
			tgl <= 1'b0;
			mreq <= 1'b0;
			sel <= (sel == 2'h2) ? 2'h0 : sel + 2'h1;
			repeat (5) @(posedge clk);
		end
	endtask
	task results;
		$display("checks=%0d errors=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results;
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{rst_n, psel, pen, pwr, tgl, mreq, lat, oe, serr} = 9'h0;
		{paddr, pwdata, sel, t1, t3} = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rc(`TCU_OFS_STD_CTRL, 32'h0);
		rv(16'h0);
		rc(8'h20, 32'h0);
		chk(serr, 1'b1);
		wr(`TCU_OFS_T3_CTRL, 32'h1);
		@(posedge clk);
		chk(stb, `TCU_TB_THIRD);
		chk(etb, `TCU_TB_FIRST);
		wr(`TCU_OFS_ENH_CTRL, 32'hc);
		@(posedge clk);
		chk(etb, `TCU_TB_SECOND);
		wr(`TCU_OFS_ENH_CTRL, 32'h0);
		md(`TCU_MODE_CAP_RISE);
		t3 <= 16'h1234;
		evt(0, 1);
		rv(16'h1234);
		rc(`TCU_OFS_FLAGS, 32'h1);
		wr(`TCU_OFS_IRQ_EN, 32'h1);
		@(posedge clk);
		chk(sirq, 1'b1);
		wr(`TCU_OFS_IRQ_EN, 32'h0);
		t3 <= 16'hbeef;
		evt(0, 2);
		rv(16'hbeef);
		rc(`TCU_OFS_FLAGS, 32'h1);
		md(`TCU_MODE_CAP_FALL);
		wr(`TCU_OFS_FLAGS, 32'h1);
		t3 <= 16'h1111;
		evt(0, 1);
		rv(16'h1111);
		wr(`TCU_OFS_FLAGS, 32'h1);
		t3 <= 16'h2222;
		evt(0, 1);
		rv(16'h1111);
		rc(`TCU_OFS_FLAGS, 32'h0);
		md(`TCU_MODE_OFF);
		md(`TCU_MODE_CAP_DIV4);
		t3 <= 16'h0444;
		evt(0, 4);
		md(`TCU_MODE_OFF);
		md(`TCU_MODE_CAP_DIV4);
		evt(0, 6);
		rv(16'h1111);
		evt(0, 2);
		rv(16'h0444);
		evt(0, 4);
		md(`TCU_MODE_CAP_DIV16);
		wr(`TCU_OFS_FLAGS, 32'h1);
		t3 <= 16'h0777;
		evt(0, 26);
		rv(16'h0444);
		evt(0, 2);
		rv(16'h0777);
		md(`TCU_MODE_OFF);
		md(`TCU_MODE_CAP_RISE);
		oe <= 1'b1;
		t3 <= 16'h0b0b;
		evt(1, 2);
		rv(16'h0b0b);
		oe <= 1'b0;
		wr(`TCU_OFS_BUS_IO, 32'h1);
		md(`TCU_MODE_OFF);
		md(`TCU_MODE_CAP_DIV4);
		t3 <= 16'h0c0c;
		evt(0, 2);
		evt(2, 3);
		rv(16'h0b0b);
		evt(2, 1);
		rv(16'h0c0c);
		md(`TCU_MODE_CAP_FALL);
		t3 <= 16'h0d0d;
		evt(2, 1);
		rv(16'h0d0d);
		wr(`TCU_OFS_ENH_VAL, 32'h50);
		wr(`TCU_OFS_ENH_CTRL, {28'h0, `TCU_MODE_CMP_SEV});
		t1 <= 16'h0050;
		repeat (4) @(posedge clk);
		chk(n_adc, 1);
		chk(n_clr, 1);
		rc(`TCU_OFS_FLAGS, 32'h3);
		results;
	end
endmodule
bind tcu_top tcu_checker #(.ADDR_W(ADDR_W)) i_tcu_checker (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .STD_TIMEBASE_O(STD_TIMEBASE_O), .ENH_TIMEBASE_O(ENH_TIMEBASE_O),
	.FIRST_TIMER_CLR_O(FIRST_TIMER_CLR_O), .THIRD_TIMER_CLR_O(THIRD_TIMER_CLR_O), .ADC_START_O(ADC_START_O),
	.STD_FLAG_O(STD_FLAG_O),
	.ENH_FLAG_O(ENH_FLAG_O), .STD_IRQ_O(STD_IRQ_O), .ENH_IRQ_O(ENH_IRQ_O));

// ==== verilog/tcu_chan.v ====
// One capture/compare channel: edge qualification, prescaler and compare match.
`include "tcu_defs.vh"

module tcu_chan #(
	parameter CNT_W = 4,
	parameter TW = 16
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [3:0] mode_i,
	input wire pin_lvl_i,
	input wire msg_sel_i,
	input wire msg_stb_i,
	input wire [TW-1:0] tmr_i,
	input wire [TW-1:0] val_i,
	output wire cap_o,
	output wire cmp_o,
	output wire sev_o,
	output wire spur_o
);

	reg lvl_prev_r;
	reg [CNT_W-1:0] cnt_r;
	reg [CNT_W-1:0] cnt_nxt;
	reg [3:0] mode_r;
	reg match_r;
	reg hit;
	wire is_cap;
	wire was_cap;
	wire is_cmp;
	wire rise;
	wire fall;
	wire raw;
	wire match;

	assign is_cap = (mode_i[3:2] == `TCU_GRP_CAP);
	assign was_cap = (mode_r[3:2] == `TCU_GRP_CAP);
	assign is_cmp = (mode_i == `TCU_MODE_CMP_TGL) || (mode_i[3:2] == `TCU_GRP_CMP);
	assign rise = pin_lvl_i & ~lvl_prev_r;
	assign fall = ~pin_lvl_i & lvl_prev_r;
	// The message strobe takes the place of pin events when selected.
	assign raw = msg_sel_i ? msg_stb_i : ((mode_i == `TCU_MODE_CAP_FALL) ? fall : rise);

	always @* begin
		case (mode_i)
			`TCU_MODE_CAP_DIV4: hit = (cnt_r >= `TCU_LAST_DIV4);
			`TCU_MODE_CAP_DIV16: hit = (cnt_r >= `TCU_LAST_DIV16);
			default: hit = 1'b1;
		endcase
	end

	// The counter is kept across a switch between prescale settings, so the first capture may come early.
	always @* begin
		cnt_nxt = cnt_r;
		if (!is_cap) begin
			cnt_nxt = {CNT_W{1'b0}};
		end else if (raw) begin
			cnt_nxt = hit ? {CNT_W{1'b0}} : cnt_r + 1'b1;
		end
	end

	assign cap_o = is_cap & raw & hit;
	assign spur_o = is_cap & was_cap & (mode_i != mode_r);
	assign match = (tmr_i == val_i);
	assign cmp_o = is_cmp & match & ~match_r;
	assign sev_o = cmp_o & (mode_i == `TCU_MODE_CMP_SEV);

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lvl_prev_r <= 1'b0;
			cnt_r <= {CNT_W{1'b0}};
			mode_r <= `TCU_RST_MODE;
			match_r <= 1'b0;
		end else begin
			lvl_prev_r <= pin_lvl_i;
			cnt_r <= cnt_nxt;
			mode_r <= mode_i;
			match_r <= is_cmp & match;
		end
	end

endmodule

// ==== verilog/tcu_top.v ====
// Timer capture unit top: APB registers, pin synchronisers, two channels and timer routing.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`include "tcu_defs.vh"

// ----------------------------------------------------------------------------
// Top module
// ----------------------------------------------------------------------------
module tcu_top #(
	parameter ADDR_W = 8,
	parameter TW = 16,
	parameter NBUF = 3,
	parameter CNT_W = 4
) (
	input wire CLK_I,
	input wire RST_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output wire PREADY_O,
	output wire PSLVERR_O,
	output wire [31:0] PRDATA_O,
	input wire STD_PAD_I,
	input wire STD_PORT_LAT_I,
	input wire STD_PORT_OE_I,
	input wire ENH_PAD_I,
	input wire ENH_PORT_LAT_I,
	input wire ENH_PORT_OE_I,
	input wire [NBUF-1:0] MSG_RX_I,
	input wire [TW-1:0] FIRST_TIMER_I,
	input wire [TW-1:0] THIRD_TIMER_I,
	output wire [1:0] STD_TIMEBASE_O,
	output wire [1:0] ENH_TIMEBASE_O,
	output wire FIRST_TIMER_CLR_O,
	output wire THIRD_TIMER_CLR_O,
	output wire ADC_START_O,
	output wire STD_FLAG_O,
	output wire ENH_FLAG_O,
	output wire STD_IRQ_O,
	output wire ENH_IRQ_O
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	reg [3:0] std_mode_r;
	reg [3:0] enh_mode_r;
	reg [TW-1:0] std_val_r;
	reg [TW-1:0] std_val_nxt;
	reg [TW-1:0] enh_val_r;
	reg [TW-1:0] enh_val_nxt;
	reg [1:0] tsel_r;
	reg msg_sel_r;
	reg [1:0] flag_r;
	reg [1:0] flag_nxt;
	reg [1:0] irq_en_r;
	reg [31:0] prdata_r;
	reg [31:0] rd_nxt;
	reg std_pad_s1_r;
	reg std_pad_s2_r;
	reg enh_pad_s1_r;
	reg enh_pad_s2_r;
	reg first_clr_r;
	reg third_clr_r;
	reg adc_start_r;
	reg [1:0] std_tb;
	reg [1:0] enh_tb;
	reg mapped;
	wire setup;
	wire wr;
	wire std_lvl;
	wire enh_lvl;
	wire msg_stb;
	wire [TW-1:0] std_tmr;
	wire [TW-1:0] enh_tmr;
	wire std_cap;
	wire std_cmp;
	wire std_sev;
	wire std_spur;
	wire enh_cap;
	wire enh_cmp;
	wire enh_sev;
	wire enh_spur;
	wire [1:0] flag_set;
	wire [1:0] flag_clr;

	// ------------------------------------------------------------------------
	// Pin synchronisers and event sources
	// ------------------------------------------------------------------------
	// The pads are asynchronous; only the second stage is looked at.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			std_pad_s1_r <= 1'b0;
			std_pad_s2_r <= 1'b0;
			enh_pad_s1_r <= 1'b0;
			enh_pad_s2_r <= 1'b0;
		end else begin
			std_pad_s1_r <= STD_PAD_I;
			std_pad_s2_r <= std_pad_s1_r;
			enh_pad_s1_r <= ENH_PAD_I;
			enh_pad_s2_r <= enh_pad_s1_r;
		end
	end

	// A pin driven as an output shows its port latch, so a port write makes an edge.
	// The latch is on this clock already and so skips the synchroniser.
	assign std_lvl = STD_PORT_OE_I ? STD_PORT_LAT_I : std_pad_s2_r;
	assign enh_lvl = ENH_PORT_OE_I ? ENH_PORT_LAT_I : enh_pad_s2_r;

	// Any receive buffer taking a message gives one strobe toward the first channel.
	assign msg_stb = |MSG_RX_I;

	// ------------------------------------------------------------------------
	// Time base selection
	// ------------------------------------------------------------------------
	// Each select bit set picks the third timer; clear picks the first.
	assign std_tmr = tsel_r[`TCU_BIT_STD] ? THIRD_TIMER_I : FIRST_TIMER_I;
	assign enh_tmr = tsel_r[`TCU_BIT_ENH] ? THIRD_TIMER_I : FIRST_TIMER_I;

	// PWM always runs on the second timer, so two PWM channels share its rate.
	always @* begin
		if (std_mode_r[3:2] == `TCU_GRP_PWM) begin
			std_tb = `TCU_TB_SECOND;
		end else if (tsel_r[`TCU_BIT_STD]) begin
			std_tb = `TCU_TB_THIRD;
		end else begin
			std_tb = `TCU_TB_FIRST;
		end
	end

	always @* begin
		if (enh_mode_r[3:2] == `TCU_GRP_PWM) begin
			enh_tb = `TCU_TB_SECOND;
		end else if (tsel_r[`TCU_BIT_ENH]) begin
			enh_tb = `TCU_TB_THIRD;
		end else begin
			enh_tb = `TCU_TB_FIRST;
		end
	end

	assign STD_TIMEBASE_O = std_tb;
	assign ENH_TIMEBASE_O = enh_tb;

	// ------------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------------
	tcu_chan #(
		.CNT_W(CNT_W),
		.TW(TW)
	) u_std (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.mode_i(std_mode_r),
		.pin_lvl_i(std_lvl),
		.msg_sel_i(msg_sel_r),
		.msg_stb_i(msg_stb),
		.tmr_i(std_tmr),
		.val_i(std_val_r),
		.cap_o(std_cap),
		.cmp_o(std_cmp),
		.sev_o(std_sev),
		.spur_o(std_spur)
	);

	// The message time-stamp feeds only the first channel.
	tcu_chan #(
		.CNT_W(CNT_W),
		.TW(TW)
	) u_enh (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.mode_i(enh_mode_r),
		.pin_lvl_i(enh_lvl),
		.msg_sel_i(1'b0),
		.msg_stb_i(1'b0),
		.tmr_i(enh_tmr),
		.val_i(enh_val_r),
		.cap_o(enh_cap),
		.cmp_o(enh_cmp),
		.sev_o(enh_sev),
		.spur_o(enh_spur)
	);

	// ------------------------------------------------------------------------
	// Special event triggers
	// ------------------------------------------------------------------------
	// A trigger clears whichever timer its channel uses, and a capture on that timer sees the clear.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			first_clr_r <= 1'b0;
			third_clr_r <= 1'b0;
			adc_start_r <= 1'b0;
		end else begin
			first_clr_r <= (std_sev & ~tsel_r[`TCU_BIT_STD]) | (enh_sev & ~tsel_r[`TCU_BIT_ENH]);
			third_clr_r <= (std_sev & tsel_r[`TCU_BIT_STD]) | (enh_sev & tsel_r[`TCU_BIT_ENH]);
			adc_start_r <= enh_sev;
		end
	end

	assign FIRST_TIMER_CLR_O = first_clr_r;
	assign THIRD_TIMER_CLR_O = third_clr_r;
	assign ADC_START_O = adc_start_r;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	assign setup = PSEL_I & ~PENABLE_I;
	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign PREADY_O = 1'b1;

	always @* begin
		case (PADDR_I)
			`TCU_OFS_STD_CTRL: mapped = 1'b1;
			`TCU_OFS_ENH_CTRL: mapped = 1'b1;
			`TCU_OFS_STD_VAL: mapped = 1'b1;
			`TCU_OFS_ENH_VAL: mapped = 1'b1;
			`TCU_OFS_T3_CTRL: mapped = 1'b1;
			`TCU_OFS_BUS_IO: mapped = 1'b1;
			`TCU_OFS_FLAGS: mapped = 1'b1;
			`TCU_OFS_IRQ_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

	always @* begin
		rd_nxt = 32'h0000_0000;
		case (PADDR_I)
			`TCU_OFS_STD_CTRL: rd_nxt[`TCU_MODE_MSB:0] = std_mode_r;
			`TCU_OFS_ENH_CTRL: rd_nxt[`TCU_MODE_MSB:0] = enh_mode_r;
			`TCU_OFS_STD_VAL: rd_nxt[TW-1:0] = std_val_r;
			`TCU_OFS_ENH_VAL: rd_nxt[TW-1:0] = enh_val_r;
			`TCU_OFS_T3_CTRL: rd_nxt[1:0] = tsel_r;
			`TCU_OFS_BUS_IO: rd_nxt[`TCU_BIT_MSG_SEL] = msg_sel_r;
			`TCU_OFS_FLAGS: rd_nxt[1:0] = flag_r;
			`TCU_OFS_IRQ_EN: rd_nxt[1:0] = irq_en_r;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Read data are sampled in the setup cycle; the access cycle follows with no wait.
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			prdata_r <= rd_nxt;
		end
	end

	assign PRDATA_O = prdata_r;

	// ------------------------------------------------------------------------
	// Captured values
	// ------------------------------------------------------------------------
	// A capture beats a software write in the same cycle; no overrun guard exists.
	always @* begin
		std_val_nxt = std_val_r;
		if (std_cap) begin
			std_val_nxt = std_tmr;
		end else if (wr && PADDR_I == `TCU_OFS_STD_VAL) begin
			std_val_nxt = PWDATA_I[TW-1:0];
		end
	end

	always @* begin
		enh_val_nxt = enh_val_r;
		if (enh_cap) begin
			enh_val_nxt = enh_tmr;
		end else if (wr && PADDR_I == `TCU_OFS_ENH_VAL) begin
			enh_val_nxt = PWDATA_I[TW-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------------
	// Writing one clears a flag, but a new event in the same cycle keeps it set.
	assign flag_set[`TCU_BIT_STD] = std_cap | std_cmp | std_spur;
	assign flag_set[`TCU_BIT_ENH] = enh_cap | enh_cmp | enh_spur;
	assign flag_clr = (wr && PADDR_I == `TCU_OFS_FLAGS) ? PWDATA_I[1:0] : `TCU_RST_BITS;

	always @* begin
		flag_nxt = (flag_r & ~flag_clr) | flag_set;
	end

	assign STD_FLAG_O = flag_r[`TCU_BIT_STD];
	assign ENH_FLAG_O = flag_r[`TCU_BIT_ENH];
	assign STD_IRQ_O = flag_r[`TCU_BIT_STD] & irq_en_r[`TCU_BIT_STD];
	assign ENH_IRQ_O = flag_r[`TCU_BIT_ENH] & irq_en_r[`TCU_BIT_ENH];

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			std_mode_r <= `TCU_RST_MODE;
			enh_mode_r <= `TCU_RST_MODE;
			std_val_r <= `TCU_RST_VAL;
			enh_val_r <= `TCU_RST_VAL;
			tsel_r <= `TCU_RST_BITS;
			msg_sel_r <= 1'b0;
			flag_r <= `TCU_RST_BITS;
			irq_en_r <= `TCU_RST_BITS;
		end else begin
			std_val_r <= std_val_nxt;
			enh_val_r <= enh_val_nxt;
			flag_r <= flag_nxt;
			if (wr && PADDR_I == `TCU_OFS_STD_CTRL) begin
				std_mode_r <= PWDATA_I[`TCU_MODE_MSB:0];
			end
			if (wr && PADDR_I == `TCU_OFS_ENH_CTRL) begin
				enh_mode_r <= PWDATA_I[`TCU_MODE_MSB:0];
			end
			if (wr && PADDR_I == `TCU_OFS_T3_CTRL) begin
				tsel_r <= PWDATA_I[1:0];
			end
			if (wr && PADDR_I == `TCU_OFS_BUS_IO) begin
				msg_sel_r <= PWDATA_I[`TCU_BIT_MSG_SEL];
			end
			if (wr && PADDR_I == `TCU_OFS_IRQ_EN) begin
				irq_en_r <= PWDATA_I[1:0];
			end
		end
	end

endmodule
